//--- ufp_cfg.svh
// timing counts and constants for the fifo port host controller
`ifndef UFP_CFG_SVH
`define UFP_CFG_SVH

`define UFP_CLK_NS 100
`define UFP_RD_ACTIVE_NS 50
`define UFP_RD_PRECHARGE_NS 50
`define UFP_FLAG_INACTIVE_NS 80
`define UFP_WR_ACTIVE_NS 50
`define UFP_WR_PRECHARGE_NS 50
`define UFP_DATA_VALID_NS 50
`define UFP_WAKE_PULSE_NS 50
// least times round up to whole cycles, never under one
`define UFP_CYC(ns) ((((ns) + `UFP_CLK_NS - 1) / `UFP_CLK_NS) < 1 ? 1 : \
    (((ns) + `UFP_CLK_NS - 1) / `UFP_CLK_NS))
`define UFP_RD_ACTIVE_CYC `UFP_CYC(`UFP_RD_ACTIVE_NS > `UFP_DATA_VALID_NS ? \
    `UFP_RD_ACTIVE_NS : `UFP_DATA_VALID_NS)
`define UFP_RD_GAP_CYC `UFP_CYC(`UFP_RD_PRECHARGE_NS + `UFP_FLAG_INACTIVE_NS)
`define UFP_WR_ACTIVE_CYC `UFP_CYC(`UFP_WR_ACTIVE_NS)
`define UFP_WR_GAP_CYC `UFP_CYC(`UFP_WR_PRECHARGE_NS)
`define UFP_WAKE_CYC `UFP_CYC(`UFP_WAKE_PULSE_NS)
`define UFP_CNT_W 4
`define UFP_DATA_W 8

`endif

//--- ufp_dev_model.sv
// behavioural model of one byte fifo channel of the bridge device
`timescale 1ns/1ps
`default_nettype none
module ufp_dev_model (
    input wire logic rst_b,
    input wire ufp_pkg::ufp_pins_out_type host,
    output ufp_pkg::ufp_pins_in_type dev
);
    import ufp_pkg::*;
    logic [7:0] rxm [8];
    logic [7:0] txm [8];
    logic [7:0] wlast = 8'h00;
    logic rxh = 0, txh = 0, pwr_n = 0;
    int rp = 0, rn = 0, tn = 0, tmax = 8, resumes = 0, flushes = 0;
    // flags float to the pull-ups in reset and idle 80 ns after a strobe
    assign dev.rx_data_avail_n = !rst_b || rxh || rp == rn;
    assign dev.tx_space_avail_n = !rst_b || txh || tn >= tmax;
    assign dev.power_enable_n = pwr_n;
    // head byte while read low, else host byte or pull-ups
    assign dev.bus_in = !host.rd_n ? rxm[rp % 8] :
        (host.bus_oe != 8'h00 ? host.bus_out : 8'hff);
    always @(posedge host.rd_n)
    begin
        if (rst_b && rp != rn) rp++;
        rxh = 1;
        #80 rxh = 0;
    end
    // byte kept only while strobe and drive are both up, so release cannot race
    always @(host.bus_out or host.bus_oe or host.wr)
        if (host.wr === 1'b1 && host.bus_oe === 8'hff) wlast = host.bus_out;
    always @(negedge host.wr)
    begin
        if (rst_b && tn < tmax) txm[tn++ % 8] = wlast;
        txh = 1;
        #80 txh = 0;
    end
    // suspend level picks resume or flush
    always @(negedge host.send_now_wake)
        if (rst_b && pwr_n) resumes++;
        else if (rst_b) flushes++;
endmodule
`default_nettype wire

//--- ufp_host.sv
// host controller that drives one channel of the byte fifo port
// Functional notes
// - read only while receive flag low, strobe low-high
// - write only while space flag low, strobe high-low
// - read low 50 ns, gap 50 plus 80
// - write high 50 ns, precharge 50 ns
`timescale 1ns/1ps
`default_nettype none
`include "ufp_cfg.svh"

module ufp_host
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire ufp_pkg::ufp_pins_in_type pins_in,
    output ufp_pkg::ufp_pins_out_type pins_out,
    input wire logic rd_req,
    output logic rd_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic wr_req,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    output logic wr_done,
    input wire logic wake_req,
    output logic wake_ready,
    output logic suspended
);
    import ufp_pkg::*;

    // sequencer for one channel; a second channel takes its own copy
    ufp_state_type state;
    ufp_state_type next_state;
    logic [`UFP_CNT_W-1:0] cnt;
    logic [`UFP_CNT_W-1:0] next_cnt;

    // write byte, wake timer and registered pin drive
    logic [7:0] wr_hold;
    logic [`UFP_CNT_W-1:0] wake_cnt;
    logic rd_strobe;
    logic wr_strobe;
    logic bus_drive;

    // counter load for a phase of n cycles; the phase ends at zero
    function automatic logic [`UFP_CNT_W-1:0] cyc(input integer n);
        cyc = n[`UFP_CNT_W-1:0] - 4'h1;
    endfunction

    // last cycle of a timed phase; sampling and pulses key off it
    function automatic logic phase_end(
        input ufp_state_type now,
        input ufp_state_type phase,
        input logic [`UFP_CNT_W-1:0] count
    );
        phase_end = (now == phase) && (count == 4'h0);
    endfunction

    // a read or write request is only taken when the device flag allows it
    assign rd_ready = (state == ufp_idle) && !pins_in.rx_data_avail_n;
    assign wr_ready = (state == ufp_idle) && !pins_in.tx_space_avail_n
        && !rd_req;
    assign wake_ready = (wake_cnt == 4'h0);
    assign suspended = pins_in.power_enable_n;

    // sequencing; reads win over writes to drain the device first
    always_comb
    begin
        next_state = state;
        next_cnt = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
        case (state)
            ufp_idle:
            begin
                if (rd_req && rd_ready)
                begin
                    next_state = ufp_rd_low;
                    next_cnt = cyc(`UFP_RD_ACTIVE_CYC);
                end
                else if (wr_req && wr_ready)
                begin
                    next_state = ufp_wr_high;
                    next_cnt = cyc(`UFP_WR_ACTIVE_CYC);
                end
            end
            ufp_rd_low:
            begin
                if (cnt == 4'h0)
                begin
                    next_state = ufp_rd_gap;
                    next_cnt = cyc(`UFP_RD_GAP_CYC);
                end
            end
            ufp_rd_gap:
            begin
                if (cnt == 4'h0)
                    next_state = ufp_idle;
            end
            ufp_wr_high:
            begin
                if (cnt == 4'h0)
                begin
                    next_state = ufp_wr_gap;
                    next_cnt = cyc(`UFP_WR_GAP_CYC);
                end
            end
            ufp_wr_gap:
            begin
                // flag recovery is watched in idle, so only precharge here
                if (cnt == 4'h0)
                    next_state = ufp_idle;
            end
            default:
            begin
                next_state = ufp_idle;
                next_cnt = 4'h0;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            state <= ufp_idle;
        else
            state <= next_state;
    end

    // phase counter; cleared in reset so no stale width survives it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            cnt <= 4'h0;
        else
            cnt <= next_cnt;
    end

    // write byte held steady across the whole strobe for setup and hold
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            wr_hold <= 8'h00;
        else if (state == ufp_idle && wr_req && wr_ready)
            wr_hold <= wr_data;
    end

    // sample the head byte at the end of the low phase, past valid-data time
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rd_data <= 8'h00;
        else if (phase_end(state, ufp_rd_low, cnt))
            rd_data <= pins_in.bus_in;
    end

    // one-cycle valid pulse alongside the sampled byte
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rd_valid <= 1'b0;
        else
            rd_valid <= phase_end(state, ufp_rd_low, cnt);
    end

    // done pulse when the write strobe falls
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            wr_done <= 1'b0;
        else
            wr_done <= phase_end(state, ufp_wr_high, cnt);
    end

    // wake strobe: one low pulse; meaning depends on power state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            wake_cnt <= 4'h0;
        else if (wake_req && wake_cnt == 4'h0)
            wake_cnt <= 4'(`UFP_WAKE_CYC);
        else if (wake_cnt != 4'h0)
            wake_cnt <= wake_cnt - 4'h1;
    end

    // read strobe registered so the pin never glitches
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rd_strobe <= 1'b0;
        else
            rd_strobe <= (next_state == ufp_rd_low);
    end

    // write strobe; byte and strobe rise together, setup counts to the fall
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            wr_strobe <= 1'b0;
        else
            wr_strobe <= (next_state == ufp_wr_high);
    end

    // bus released unless writing, so other parts may share the lines
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            bus_drive <= 1'b0;
        else
            bus_drive <= (next_state == ufp_wr_high);
    end

    // pin outputs; wake line idles high between pulses
    assign pins_out.rd_n = !rd_strobe;
    assign pins_out.wr = wr_strobe;
    assign pins_out.send_now_wake = (wake_cnt == 4'h0);
    assign pins_out.bus_out = wr_hold;
    assign pins_out.bus_oe = {8{bus_drive}};
endmodule

`default_nettype wire

//--- ufp_host_assertions.sv
// pin timing checker for the fifo port host controller
`timescale 1ns/1ps
`default_nettype none
module ufp_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire ufp_pkg::ufp_pins_in_type pins_in,
    input wire ufp_pkg::ufp_pins_out_type pins_out,
    input wire logic rd_valid,
    input wire logic wr_done
);
    import ufp_pkg::*;
    wire logic rdn = pins_out.rd_n;
    wire logic wr = pins_out.wr;
    wire logic wk = pins_out.send_now_wake;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // strobes start only on a ready flag and keep their widths and gaps
    property p_rf; $fell(rdn) |-> !$past(pins_in.rx_data_avail_n); endproperty
    a_rf: assert property (p_rf) else $error("read while empty");
    property p_rl; $fell(rdn) |-> ##[1:2] rdn; endproperty
    a_rl: assert property (p_rl) else $error("read low too long");
    property p_rg; $rose(rdn) |-> rd_valid ##1 rdn [*2]; endproperty
    a_rg: assert property (p_rg) else $error("read gap");
    property p_wf; $rose(wr) |-> !$past(pins_in.tx_space_avail_n); endproperty
    a_wf: assert property (p_wf) else $error("write while full");
    property p_wp; $rose(wr) |=> $fell(wr) && wr_done; endproperty
    a_wp: assert property (p_wp) else $error("write pulse");
    property p_wg; $fell(wr) |=> !wr; endproperty
    a_wg: assert property (p_wg) else $error("write precharge");
    // the host drives the shared lines only inside a write strobe
    property p_oe; pins_out.bus_oe != 8'h00 |-> wr && rdn; endproperty
    a_oe: assert property (p_oe) else $error("bus driven");
    property p_wk; $fell(wk) |=> $rose(wk); endproperty
    a_wk: assert property (p_wk) else $error("wake pulse");
endmodule
bind ufp_host ufp_chk u_ufp_chk(.sys_clk(sys_clk), .rst_b(rst_b), .pins_in(pins_in),
    .pins_out(pins_out), .rd_valid(rd_valid), .wr_done(wr_done));
`default_nettype wire

//--- ufp_pkg.sv
// types for the fifo port host controller
package ufp_pkg;
    typedef enum logic [2:0] {
        ufp_idle,
        ufp_rd_low,
        ufp_rd_gap,
        ufp_wr_high,
        ufp_wr_gap
    } ufp_state_type;

    // pins toward the device
    typedef struct packed {
        logic rd_n;
        logic wr;
        logic send_now_wake;
        logic [7:0] bus_out;
        logic [7:0] bus_oe;
    } ufp_pins_out_type;

    typedef struct packed {
        logic rx_data_avail_n;
        logic tx_space_avail_n;
        logic power_enable_n;
        logic [7:0] bus_in;
    } ufp_pins_in_type;
endpackage

//--- usb_parallel_fifo_port_tb_top.sv
// testbench for the fifo port host controller
`timescale 1ns/1ps
`default_nettype none
module usb_parallel_fifo_port_tb_top;
    import ufp_pkg::*;
    logic sys_clk = 0, rst_b = 0, rd_req = 0, wr_req = 0, wake_req = 0;
    logic rd_ready, rd_valid, wr_ready, wr_done, wake_ready, suspended;
    logic [7:0] wr_data = 8'h00, rd_data;
    ufp_pins_in_type pins_in;
    ufp_pins_out_type pins_out;
    int err_count = 0, comparisons = 0;
    ufp_host u_ufp_host(.sys_clk(sys_clk), .rst_b(rst_b), .pins_in(pins_in),
        .pins_out(pins_out), .rd_req(rd_req), .rd_ready(rd_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr_req(wr_req), .wr_data(wr_data), .wr_ready(wr_ready),
        .wr_done(wr_done), .wake_req(wake_req), .wake_ready(wake_ready), .suspended(suspended));
    ufp_dev_model u_ufp_dev_model(.rst_b(rst_b), .host(pins_out), .dev(pins_in));
    initial
        forever #50 sys_clk = ~sys_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // requests stay up until the answer, sampled mid-cycle
    task rd1(input logic [7:0] e);
        rd_req = 1;
        repeat (20) if (rd_valid !== 1'b1) @(negedge sys_clk);
        rd_req = 0;
        chk({7'h0, rd_valid}, 8'h01);
        chk(rd_data, e);
        // let an edge pass so the next request is a fresh level
        @(negedge sys_clk);
    endtask
    task wr1(input logic [7:0] b);
        wr_data = b;
        wr_req = 1;
        repeat (20) if (wr_done !== 1'b1) @(negedge sys_clk);
        wr_req = 0;
        chk({7'h0, wr_done}, 8'h01);
        @(negedge sys_clk);
    endtask
    task wk1;
        wake_req = 1;
        @(negedge sys_clk);
        chk({6'h0, pins_out.send_now_wake, wake_ready}, 8'h00);
        wake_req = 0;
        repeat (3) @(negedge sys_clk);
        chk({6'h0, pins_out.send_now_wake, wake_ready}, 8'h03);
    endtask
    task t_rd;
        u_ufp_dev_model.rxm[0] = 8'h5a;
        u_ufp_dev_model.rxm[1] = 8'hc3;
        u_ufp_dev_model.rn = 2;
        rd1(8'h5a);
        rd1(8'hc3);
        rd_req = 1;
        repeat (8)
        begin
            @(negedge sys_clk);
            chk({6'h0, pins_out.rd_n, rd_ready}, 8'h02);
            chk(pins_out.bus_oe, 8'h00);
        end
        rd_req = 0;
        chk(8'(u_ufp_dev_model.rp), 8'h02);
        $display("read test done");
    endtask
    task t_wr;
        wr1(8'ha5);
        wr1(8'h3c);
        u_ufp_dev_model.tmax = 2;
        wr_req = 1;
        repeat (8)
        begin
            @(negedge sys_clk);
            chk({6'h0, pins_out.wr, wr_ready}, 8'h00);
        end
        chk(8'(u_ufp_dev_model.tn), 8'h02);
        u_ufp_dev_model.tmax = 8;
        wr1(8'h77);
        chk(u_ufp_dev_model.txm[0], 8'ha5);
        chk(u_ufp_dev_model.txm[1], 8'h3c);
        chk(u_ufp_dev_model.txm[2], 8'h77);
        $display("write test done");
    endtask
    task t_wk;
        wk1;
        chk(8'(u_ufp_dev_model.flushes), 8'h01);
        u_ufp_dev_model.pwr_n = 1;
        wk1;
        chk(8'(u_ufp_dev_model.resumes), 8'h01);
        chk({7'h0, suspended}, 8'h01);
        $display("wake test done");
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge sys_clk);
        rst_b = 1;
        t_rd;
        t_wr;
        t_wk;
        results;
    end
    // tests need some 50 cycles; cut off at 1000
    initial
    begin
        #100000;
        err_count++;
        results;
    end
endmodule
`default_nettype wire
